//--- hw/perf_params.svh
`ifndef PERF_PARAMS_SVH
`define PERF_PARAMS_SVH

// ****************************************
// Event codes
// ****************************************
`define EV_CYCLES    7'h00
`define EV_INSTR     7'h01
`define EV_BRANCH    7'h02
`define EV_RETURN    7'h03
`define EV_INDIRECT  7'h04
`define EV_INSTRUCTION_TRANSLATION_BUFFER      7'h05
`define EV_DATA_TRANSLATION_BUFFER      7'h06
`define EV_JOINT_TRANSLATION_BUFFER_I    7'h07
`define EV_JOINT_TRANSLATION_BUFFER_D    7'h08
`define EV_CMISS     7'h0D
`define EV_ZERO_DST  7'h11
`define EV_STALL     7'h12
`define EV_SC        7'h13
`define EV_PREFETCH_INSTRUCTION      7'h14
`define EV_SINGLE    7'h17
`define EV_FIXUP     7'h18
`define EV_ITS       7'h20
`define EV_LONG      7'h2C
`define EV_SYS_FIRST 7'h40
`define EV_SYS_LAST  7'h43

// ****************************************
// Widths and reset values
// ****************************************
`define CNT_W        32
`define CNT_MSB      31
`define CNT_RST      32'h0000_0000
`define CNT_ONE      32'h0000_0001
`define SLOTS        20

`endif

//--- hw/pec_pkg.sv
// ****************************************
// Shared types
// ****************************************
package pec_pkg;
  typedef logic [6:0]  event_code_t;
  typedef logic [31:0] count_t;
  typedef logic [7:0]  tc_id_t;
  typedef logic [3:0]  vp_id_t;
  typedef enum logic [1:0] {
    MT_ALL = 2'b00,
    MT_VP  = 2'b01,
    MT_TC  = 2'b10,
    MT_RSV = 2'b11
  } mt_mode_t;
  typedef enum logic [4:0] {
    SL_CYCLES   = 5'h00, SL_INSTR  = 5'h01, SL_BRANCH = 5'h02,
    SL_RETURN   = 5'h03, SL_INDIR  = 5'h04, SL_INSTRUCTION_TRANSLATION_BUFFER   = 5'h05,
    SL_DATA_TRANSLATION_BUFFER     = 5'h06, SL_JOINT_TRANSLATION_BUFFER_I = 5'h07, SL_JOINT_TRANSLATION_BUFFER_D = 5'h08,
    SL_CMISS    = 5'h09, SL_ZERO   = 5'h0A, SL_STALL  = 5'h0B,
    SL_SC       = 5'h0C, SL_PREFETCH_INSTRUCTION   = 5'h0D, SL_SINGLE = 5'h0E,
    SL_FIXUP    = 5'h0F, SL_ITS    = 5'h10, SL_LONG   = 5'h11,
    SL_SYS      = 5'h12, SL_NONE   = 5'h13
  } slot_t;
endpackage : pec_pkg

//--- hw/event_decode.sv
`include "perf_params.svh"

// ****************************************
// Event code to slot decode, one counter
// ****************************************
module event_decode #(
  parameter bit CNT1 = 1'b0
) (
  input  wire pec_pkg::event_code_t code,
  output pec_pkg::slot_t            slot,
  output logic                      no_mode
);

  // Map code onto an event slot and mode flag
  always_comb begin
    no_mode = 1'b0;
    case (code)
      `EV_CYCLES: begin
        slot    = pec_pkg::SL_CYCLES;
        no_mode = 1'b1;
      end
      `EV_INSTR:    slot = pec_pkg::SL_INSTR;
      `EV_BRANCH:   slot = pec_pkg::SL_BRANCH;
      `EV_RETURN:   slot = pec_pkg::SL_RETURN;
      `EV_INDIRECT: slot = pec_pkg::SL_INDIR;
      `EV_INSTRUCTION_TRANSLATION_BUFFER:     slot = pec_pkg::SL_INSTRUCTION_TRANSLATION_BUFFER;
      `EV_DATA_TRANSLATION_BUFFER:     slot = pec_pkg::SL_DATA_TRANSLATION_BUFFER;
      `EV_JOINT_TRANSLATION_BUFFER_I:   slot = pec_pkg::SL_JOINT_TRANSLATION_BUFFER_I;
      `EV_JOINT_TRANSLATION_BUFFER_D:   slot = pec_pkg::SL_JOINT_TRANSLATION_BUFFER_D;
      `EV_CMISS:    slot = pec_pkg::SL_CMISS;
      `EV_ZERO_DST: slot = pec_pkg::SL_ZERO;
      `EV_STALL: begin
        slot    = pec_pkg::SL_STALL;
        no_mode = !CNT1;
      end
      `EV_SC:       slot = pec_pkg::SL_SC;
      `EV_PREFETCH_INSTRUCTION:     slot = pec_pkg::SL_PREFETCH_INSTRUCTION;
      `EV_SINGLE:   slot = pec_pkg::SL_SINGLE;
      `EV_FIXUP:    slot = pec_pkg::SL_FIXUP;
      `EV_ITS:      slot = pec_pkg::SL_ITS;
      `EV_LONG:     slot = pec_pkg::SL_LONG;
      default: begin
        if (code >= `EV_SYS_FIRST && code <= `EV_SYS_LAST) begin
          slot    = pec_pkg::SL_SYS;
          no_mode = 1'b1;
        end else begin
          slot = pec_pkg::SL_NONE;
        end
      end
    endcase
  end

endmodule : event_decode

//--- hw/perf_event_counter_select.sv
`include "perf_params.svh"

module perf_event_counter_select (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // Per-counter control
  input  wire pec_pkg::event_code_t [1:0] event_sel,
  input  wire logic [1:0]                 cnt_user,
  input  wire logic [1:0]                 cnt_super,
  input  wire logic [1:0]                 cnt_kernel,
  input  wire logic [1:0]                 cnt_exl,
  input  wire logic [1:0]                 overflow_irq_enable,
  input  wire pec_pkg::mt_mode_t [1:0]    mt_mode,
  input  wire pec_pkg::tc_id_t [1:0]      sel_tc,
  input  wire pec_pkg::vp_id_t [1:0]      sel_vp,
  input  wire logic [1:0]                 cnt_wr,
  input  wire pec_pkg::count_t            cnt_wdata,
  // Current mode of the counted instruction
  input  wire logic                       mode_user,
  input  wire logic                       mode_super,
  input  wire logic                       mode_kernel,
  input  wire logic                       mode_exl,
  // Thread owning each event class
  input  wire pec_pkg::tc_id_t            ev_tc,
  input  wire pec_pkg::vp_id_t            ev_vp,
  input  wire pec_pkg::tc_id_t            fixup_tc,
  input  wire pec_pkg::vp_id_t            fixup_vp,
  input  wire pec_pkg::tc_id_t            sole_tc,
  input  wire pec_pkg::vp_id_t            sole_vp,
  // Pipeline event pulses
  input  wire logic                       instr_done,
  input  wire logic                       branch_done,
  input  wire logic                       branch_mispred,
  input  wire logic                       return_done,
  input  wire logic                       return_mispred,
  input  wire logic                       return_unpred,
  input  wire logic                       indirect_done,
  input  wire logic                       instruction_translation_buffer_access,
  input  wire logic                       instruction_translation_buffer_miss,
  input  wire logic                       instruction_translation_buffer_addr_err,
  input  wire logic                       data_translation_buffer_access,
  input  wire logic                       data_translation_buffer_miss,
  input  wire logic                       joint_translation_buffer_d_access,
  input  wire logic                       joint_translation_buffer_i_miss,
  input  wire logic                       joint_translation_buffer_d_miss,
  input  wire logic                       load_miss,
  input  wire logic                       store_miss,
  input  wire logic                       store_hit_shared,
  input  wire logic                       zero_dst_done,
  input  wire logic                       sc_done,
  input  wire logic                       sc_failed,
  input  wire logic                       prefetch_instruction_done,
  input  wire logic                       prefetch_instruction_uncached,
  input  wire logic                       prefetch_instruction_xlate_err,
  input  wire logic                       prefetch_instruction_hit,
  input  wire logic                       its_load,
  input  wire logic                       its_store,
  input  wire logic                       fetch_stall,
  input  wire logic                       alu_stall,
  input  wire logic                       replay,
  input  wire logic                       one_eligible,
  input  wire logic                       lsu_fixup,
  input  wire logic                       long_stall,
  // Asynchronous system event pins
  input  wire logic [7:0]                 system_event_in,
  // Results
  output pec_pkg::count_t [1:0]           count_q,
  output logic [1:0]                      irq_q
);

  // ****************************************
  // Thread qualification
  // ****************************************
  function automatic logic qual(input pec_pkg::mt_mode_t m, input pec_pkg::tc_id_t st,
                                input pec_pkg::vp_id_t sv, input pec_pkg::tc_id_t t,
                                input pec_pkg::vp_id_t v);
    case (m)
      pec_pkg::MT_ALL: qual = 1'b1;
      pec_pkg::MT_VP:  qual = (sv == v);
      pec_pkg::MT_TC:  qual = (st == t);
      default:         qual = 1'b0;
    endcase
  endfunction : qual

  // ****************************************
  // Pin synchroniser and miss filters
  // ****************************************
  logic [7:0] sys_meta_q;
  logic [7:0] sys_q;
  logic       instruction_translation_buffer_prev_q;
  logic       instruction_translation_buffer_prev_d;
  logic       data_translation_buffer_prev_q;
  logic       data_translation_buffer_prev_d;
  logic       instruction_translation_buffer_miss_ok;
  logic       data_translation_buffer_miss_ok;

  // Two-flop synchroniser for system event pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sys_meta_q <= 8'h00;
      sys_q      <= 8'h00;
    end else begin
      sys_meta_q <= system_event_in;
      sys_q      <= sys_meta_q;
    end
  end

  // Miss history and filtered misses
  always_comb begin
    instruction_translation_buffer_prev_d  = instruction_translation_buffer_miss;
    data_translation_buffer_prev_d  = data_translation_buffer_miss;
    instruction_translation_buffer_miss_ok = instruction_translation_buffer_miss && !instruction_translation_buffer_prev_q && !instruction_translation_buffer_addr_err;
    data_translation_buffer_miss_ok = data_translation_buffer_miss && !data_translation_buffer_prev_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      instruction_translation_buffer_prev_q <= 1'b0;
      data_translation_buffer_prev_q <= 1'b0;
    end else begin
      instruction_translation_buffer_prev_q <= instruction_translation_buffer_prev_d;
      data_translation_buffer_prev_q <= data_translation_buffer_prev_d;
    end
  end

  // ****************************************
  // Event vectors and selection
  // ****************************************
  logic [1:0][`SLOTS-1:0] cond;
  logic [1:0]             inc;
  logic [1:0]             mode_ok;
  pec_pkg::slot_t [1:0]   slot;
  logic [1:0]             no_mode;

  // One decoder per counter
  for (genvar g = 0; g < 2; g++) begin : g_dec
    event_decode #(
      .CNT1 (g == 1)
    ) u_dec (
      .code    (event_sel[g]),
      .slot    (slot[g]),
      .no_mode (no_mode[g])
    );
  end

  // Build event vectors per counter, thread-qualified except cycles, counter 0 stall and system pins
  always_comb begin
    cond = '0;
    for (int i = 0; i < 2; i++) begin
      logic qe;
      logic c1;
      qe = qual(mt_mode[i], sel_tc[i], sel_vp[i], ev_tc, ev_vp);
      c1 = (i == 1);
      mode_ok[i] = (cnt_user[i] && mode_user) || (cnt_super[i] && mode_super) ||
                   (cnt_kernel[i] && mode_kernel) || (cnt_exl[i] && mode_exl);
      cond[i][pec_pkg::SL_CYCLES] = 1'b1;
      cond[i][pec_pkg::SL_INSTR]  = qe && instr_done;
      cond[i][pec_pkg::SL_BRANCH] = qe && branch_done && (!c1 || branch_mispred);
      cond[i][pec_pkg::SL_RETURN] = qe && return_done && (!c1 || return_mispred);
      cond[i][pec_pkg::SL_INDIR]  = qe && (c1 ? return_unpred : indirect_done);
      cond[i][pec_pkg::SL_INSTRUCTION_TRANSLATION_BUFFER]   = qe && (c1 ? instruction_translation_buffer_miss_ok : instruction_translation_buffer_access);
      cond[i][pec_pkg::SL_DATA_TRANSLATION_BUFFER]   = qe && (c1 ? data_translation_buffer_miss_ok : data_translation_buffer_access);
      cond[i][pec_pkg::SL_JOINT_TRANSLATION_BUFFER_I] = qe && (c1 ? joint_translation_buffer_i_miss : instruction_translation_buffer_miss_ok);
      cond[i][pec_pkg::SL_JOINT_TRANSLATION_BUFFER_D] = qe && (c1 ? joint_translation_buffer_d_miss : joint_translation_buffer_d_access);
      cond[i][pec_pkg::SL_CMISS]  = qe && (c1 ? (store_miss || store_hit_shared) : load_miss);
      cond[i][pec_pkg::SL_ZERO]   = qe && !c1 && zero_dst_done;
      cond[i][pec_pkg::SL_STALL]  = c1 ? qe && replay : (fetch_stall || alu_stall);
      cond[i][pec_pkg::SL_SC]     = qe && sc_done && (!c1 || sc_failed);
      cond[i][pec_pkg::SL_PREFETCH_INSTRUCTION]   = qe && prefetch_instruction_done &&
                                    (c1 ? prefetch_instruction_hit : !(prefetch_instruction_uncached || prefetch_instruction_xlate_err));
      cond[i][pec_pkg::SL_SINGLE] = c1 && one_eligible &&
                                    qual(mt_mode[i], sel_tc[i], sel_vp[i], sole_tc, sole_vp);
      cond[i][pec_pkg::SL_FIXUP]  = !c1 && lsu_fixup &&
                                    qual(mt_mode[i], sel_tc[i], sel_vp[i], fixup_tc, fixup_vp);
      cond[i][pec_pkg::SL_ITS]    = qe && (c1 ? its_store : its_load);
      cond[i][pec_pkg::SL_LONG]   = c1 && qe && long_stall;
      // even pins counter 0, odd pins counter 1
      cond[i][pec_pkg::SL_SYS]    = sys_q[{event_sel[i][1:0], c1}];
      // each counter judged on its own
      inc[i] = cond[i][slot[i]] && (no_mode[i] || mode_ok[i]);
    end
  end

  // ****************************************
  // Counters and interrupt request
  // ****************************************
  pec_pkg::count_t [1:0] count_d;
  logic [1:0]            irq_d;

  // Write wins, else step by one
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      count_d[i] = cnt_wr[i] ? cnt_wdata : count_q[i] + (inc[i] ? `CNT_ONE : `CNT_RST);
      // request follows bit 31 and enable
      irq_d[i]   = count_d[i][`CNT_MSB] && overflow_irq_enable[i];
    end
  end

  // clk is the gated core clock
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_q <= {`CNT_RST, `CNT_RST};
      irq_q   <= 2'b00;
    end else begin
      count_q <= count_d;
      irq_q   <= irq_d;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_cycle_count: assert property (
    (event_sel[0] == `EV_CYCLES && !cnt_wr[0]) |=> count_q[0] == $past(count_q[0]) + `CNT_ONE)
    else $error("cycle count did not step");

  a_sys_even_pin: assert property (
    (event_sel[0] == `EV_SYS_FIRST && !cnt_wr[0] && $past(system_event_in[0], 2))
      |=> count_q[0] == $past(count_q[0]) + `CNT_ONE)
    else $error("system event pin 0 not counted");

  a_sys_odd_pin: assert property (
    (event_sel[1] == `EV_SYS_LAST && !cnt_wr[1] && !$past(system_event_in[7], 2))
      |=> count_q[1] == $past(count_q[1]))
    else $error("system event pin 7 counted while low");

  a_write_load: assert property (
    cnt_wr[1] |=> count_q[1] == $past(cnt_wdata))
    else $error("counter write lost");

  a_irq_level: assert property (
    ##1 irq_q[0] == (count_q[0][`CNT_MSB] && $past(overflow_irq_enable[0])))
    else $error("interrupt request mismatch");

  a_mode_gate: assert property (
    (event_sel[0] == `EV_INSTR && !mode_ok[0] && !cnt_wr[0]) |=> $stable(count_q[0]))
    else $error("counted outside enabled modes");

  a_stall_once: assert property (
    (event_sel[0] == `EV_STALL && fetch_stall && alu_stall && !cnt_wr[0])
      |=> count_q[0] == $past(count_q[0]) + `CNT_ONE)
    else $error("double stall not counted once");

  a_instruction_translation_buffer_filter: assert property (
    (event_sel[1] == `EV_INSTRUCTION_TRANSLATION_BUFFER && !cnt_wr[1] && instruction_translation_buffer_miss
      ##1 event_sel[1] == `EV_INSTRUCTION_TRANSLATION_BUFFER && instruction_translation_buffer_miss && !cnt_wr[1])
      |=> count_q[1] == $past(count_q[1]))
    else $error("back-to-back fetch miss counted");

  a_sc_fail_only: assert property (
    (event_sel[1] == `EV_SC && sc_done && !sc_failed && !cnt_wr[1]) |=> $stable(count_q[1]))
    else $error("successful store counted as failed");

  a_reserved_idle: assert property (
    (event_sel[0] > `EV_SYS_LAST && !cnt_wr[0]) |=> $stable(count_q[0]))
    else $error("reserved code counted");

  a_data_translation_buffer_merge: assert property (
    (event_sel[1] == `EV_DATA_TRANSLATION_BUFFER && !cnt_wr[1] && data_translation_buffer_prev_q && data_translation_buffer_miss)
      |=> $stable(count_q[1]))
    else $error("back-to-back data miss counted twice");

  a_branch_mispred: assert property (
    (event_sel[1] == `EV_BRANCH && !cnt_wr[1] && !branch_mispred) |=> $stable(count_q[1]))
    else $error("correct branch counted as mispredict");

  a_its_load: assert property (
    (event_sel[0] == `EV_ITS && !cnt_wr[0] && !its_load) |=> $stable(count_q[0]))
    else $error("inter-thread load counted without load");

  a_zero_cnt1: assert property (
    (event_sel[1] == `EV_ZERO_DST && !cnt_wr[1]) |=> $stable(count_q[1]))
    else $error("counter 1 counted zero-destination code");

  a_irq_masked: assert property (
    !overflow_irq_enable[1] |=> !irq_q[1])
    else $error("interrupt raised while disabled");

  c_irq_rise: cover property ($rose(irq_q[0]));
  c_sys_even: cover property (inc[0] && slot[0] == pec_pkg::SL_SYS);
  c_both_step: cover property (inc[0] && inc[1] && cnt_wr == 2'b00);
  c_sys_count: cover property (inc[1] && slot[1] == pec_pkg::SL_SYS);

endmodule : perf_event_counter_select

//--- tb/event_source.sv
// ****************************************
// Pipeline event source
// ****************************************
module event_source (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [32:0] ev_req,
  output logic [32:0]      ev
);
  timeunit 1ns;
  timeprecision 100ps;

  // One pulse per requested cycle; idle lines rest low like the real units
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ev <= 33'h0_0000_0000;
    end else begin
      ev <= ev_req;
    end
  end
endmodule : event_source

//--- tb/tb.sv
// ****************************************
// Counter event selection bench
// ****************************************
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int E_INSTR = 0, E_BR = 1, E_BRMIS = 2, E_RET = 3, E_RETMIS = 4, E_RETUNP = 5;
  localparam int E_IND = 6, E_IACC = 7, E_IMISS = 8, E_IERR = 9, E_DACC = 10, E_DMISS = 11;
  localparam int E_JDACC = 12, E_JIMISS = 13, E_JDMISS = 14, E_LMISS = 15, E_SMISS = 16;
  localparam int E_ZERO = 18, E_SC = 19, E_SCF = 20, E_PREFETCH_INSTRUCTION = 21, E_PUNC = 22, E_PHIT = 24;
  localparam int E_ITSL = 25, E_ITSS = 26, E_FST = 27, E_AST = 28, E_RPL = 29, E_ONE = 30;
  localparam int E_FIX = 31, E_LONG = 32, E_SHR = 17, E_PERR = 23;

  logic                       clk, clk_run, rst_n;
  pec_pkg::event_code_t [1:0] event_sel;
  logic [1:0]                 cnt_user, cnt_super, cnt_kernel, cnt_exl;
  logic [1:0]                 overflow_irq_enable, cnt_wr, irq_q;
  pec_pkg::mt_mode_t [1:0]    mt_mode;
  pec_pkg::tc_id_t [1:0]      sel_tc;
  pec_pkg::vp_id_t [1:0]      sel_vp;
  pec_pkg::count_t            cnt_wdata;
  pec_pkg::count_t [1:0]      count_q;
  logic                       mode_user, mode_super, mode_kernel, mode_exl;
  pec_pkg::tc_id_t            ev_tc, fixup_tc, sole_tc;
  pec_pkg::vp_id_t            ev_vp, fixup_vp, sole_vp;
  logic [7:0]                 system_event_in;
  logic [32:0]                ev_req, ev;
  int                         error_cnt, checked, cycles;

  event_source event_source_i (.clk(clk), .rst_n(rst_n), .ev_req(ev_req), .ev(ev));

  perf_event_counter_select perf_event_counter_select_i (
    .clk(clk), .rst_n(rst_n), .event_sel(event_sel), .cnt_user(cnt_user),
    .cnt_super(cnt_super), .cnt_kernel(cnt_kernel), .cnt_exl(cnt_exl),
    .overflow_irq_enable(overflow_irq_enable), .mt_mode(mt_mode), .sel_tc(sel_tc),
    .sel_vp(sel_vp), .cnt_wr(cnt_wr), .cnt_wdata(cnt_wdata), .mode_user(mode_user),
    .mode_super(mode_super), .mode_kernel(mode_kernel), .mode_exl(mode_exl),
    .ev_tc(ev_tc), .ev_vp(ev_vp), .fixup_tc(fixup_tc), .fixup_vp(fixup_vp),
    .sole_tc(sole_tc), .sole_vp(sole_vp), .system_event_in(system_event_in),
    .count_q(count_q), .irq_q(irq_q),
    .instr_done(ev[0]), .branch_done(ev[1]), .branch_mispred(ev[2]), .return_done(ev[3]),
    .return_mispred(ev[4]), .return_unpred(ev[5]), .indirect_done(ev[6]),
    .instruction_translation_buffer_access(ev[7]), .instruction_translation_buffer_miss(ev[8]), .instruction_translation_buffer_addr_err(ev[9]), .data_translation_buffer_access(ev[10]),
    .data_translation_buffer_miss(ev[11]), .joint_translation_buffer_d_access(ev[12]), .joint_translation_buffer_i_miss(ev[13]), .joint_translation_buffer_d_miss(ev[14]),
    .load_miss(ev[15]), .store_miss(ev[16]), .store_hit_shared(ev[17]),
    .zero_dst_done(ev[18]), .sc_done(ev[19]), .sc_failed(ev[20]), .prefetch_instruction_done(ev[21]),
    .prefetch_instruction_uncached(ev[22]), .prefetch_instruction_xlate_err(ev[23]), .prefetch_instruction_hit(ev[24]), .its_load(ev[25]),
    .its_store(ev[26]), .fetch_stall(ev[27]), .alu_stall(ev[28]), .replay(ev[29]),
    .one_eligible(ev[30]), .lsu_fixup(ev[31]), .long_stall(ev[32])
  );

  // ****************************************
  // Clock, gate and hang limit
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = clk_run ? ~clk : clk;
  end

  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      $display("CHECK FAILED run length expected below 3000 cycles seen 3000");
      wrap_up();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  function automatic logic [32:0] b(input int i);
    return 33'h0_0000_0001 << i;
  endfunction : b

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step

  task automatic check(input string what, input pec_pkg::count_t exp, input pec_pkg::count_t got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic clear(input pec_pkg::event_code_t c0, input pec_pkg::event_code_t c1);
    event_sel[0] = c0;
    event_sel[1] = c1;
    cnt_wdata = 32'h0000_0000;
    cnt_wr = 2'b11;
    step(1);
    cnt_wr = 2'b00;
  endtask : clear

  task automatic pair_run(input pec_pkg::event_code_t c0, input pec_pkg::event_code_t c1,
                          input logic [32:0] pat, input int reps, input int e0, input int e1);
    clear(c0, c1);
    ev_req = pat;
    step(reps);
    ev_req = 33'h0_0000_0000;
    step(3);
    if (e0 >= 0) check($sformatf("count0 code %0d", c0), pec_pkg::count_t'(e0), count_q[0]);
    if (e1 >= 0) check($sformatf("count1 code %0d", c1), pec_pkg::count_t'(e1), count_q[1]);
  endtask : pair_run

  task automatic wrap_up();
    $display("Checks made %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_cycles();
    pec_pkg::count_t a;
    clear(7'h00, 7'h00);
    a = count_q[0];
    step(10);
    check("cycle count", a + 32'h0000_000A, count_q[0]);
    clk_run = 1'b0;
    #200;
    check("gated clock", a + 32'h0000_000A, count_q[0]);
    clk_run = 1'b1;
    step(1);
    $display("test cycles done");
  endtask : t_cycles

  task automatic t_write_irq();
    overflow_irq_enable = 2'b01;
    cnt_wdata = 32'h7FFF_FFFE;
    cnt_wr = 2'b01;
    step(1);
    cnt_wr = 2'b00;
    check("write beats event", 32'h7FFF_FFFE, count_q[0]);
    check("irq low", 32'h0000_0000, pec_pkg::count_t'(irq_q[0]));
    step(2);
    check("bit31 reached", 32'h8000_0000, count_q[0]);
    check("irq raised", 32'h0000_0001, pec_pkg::count_t'(irq_q[0]));
    overflow_irq_enable = 2'b00;
    step(1);
    check("irq masked", 32'h0000_0000, pec_pkg::count_t'(irq_q[0]));
    overflow_irq_enable = 2'b01;
    cnt_wdata = 32'hFFFF_FFFF;
    cnt_wr = 2'b01;
    step(1);
    cnt_wr = 2'b00;
    step(1);
    check("wrap", 32'h0000_0000, count_q[0]);
    check("irq after wrap", 32'h0000_0000, pec_pkg::count_t'(irq_q[0]));
    $display("test write and irq done");
  endtask : t_write_irq

  task automatic t_events();
    pair_run(7'h01, 7'h01, b(E_INSTR), 3, 3, 3);
    pair_run(7'h02, 7'h02, b(E_BR), 2, 2, 0);
    pair_run(7'h02, 7'h02, b(E_BR) | b(E_BRMIS), 1, 1, 1);
    pair_run(7'h03, 7'h03, b(E_RET) | b(E_RETMIS), 2, 2, 2);
    pair_run(7'h04, 7'h04, b(E_IND) | b(E_RETUNP), 2, 2, 2);
    pair_run(7'h05, 7'h05, b(E_IACC) | b(E_IMISS), 3, 3, 1);
    pair_run(7'h05, 7'h05, b(E_IMISS) | b(E_IERR), 1, 0, 0);
    pair_run(7'h06, 7'h06, b(E_DACC) | b(E_DMISS), 3, 3, 1);
    pair_run(7'h07, 7'h07, b(E_IMISS) | b(E_JIMISS), 1, 1, 1);
    pair_run(7'h08, 7'h08, b(E_JDACC) | b(E_JDMISS), 2, 2, 2);
    pair_run(7'h0D, 7'h0D, b(E_LMISS) | b(E_SMISS), 2, 2, 2);
    pair_run(7'h0D, 7'h0D, b(E_SHR), 2, 0, 2);
    pair_run(7'h11, 7'h11, b(E_ZERO), 2, 2, 0);
    pair_run(7'h13, 7'h13, b(E_SC) | b(E_SCF), 1, 1, 1);
    pair_run(7'h13, 7'h13, b(E_SC), 2, 2, 0);
    pair_run(7'h14, 7'h14, b(E_PREFETCH_INSTRUCTION) | b(E_PHIT), 2, 2, 2);
    pair_run(7'h14, 7'h14, b(E_PREFETCH_INSTRUCTION) | b(E_PUNC), 2, 0, 0);
    pair_run(7'h14, 7'h14, b(E_PREFETCH_INSTRUCTION) | b(E_PERR), 2, 0, 0);
    pair_run(7'h20, 7'h20, b(E_ITSL) | b(E_ITSS), 2, 2, 2);
    pair_run(7'h12, 7'h12, b(E_FST) | b(E_AST) | b(E_RPL), 2, 2, 2);
    pair_run(7'h12, 7'h2C, b(E_FST) | b(E_LONG), 2, 2, 2);
    pair_run(7'h17, 7'h17, b(E_ONE), 3, 0, 3);
    pair_run(7'h18, 7'h18, b(E_FIX), 2, 2, -1);
    pair_run(7'h2C, 7'h2C, b(E_LONG), 2, 0, 2);
    $display("test event codes done");
  endtask : t_events

  task automatic t_mode();
    cnt_user = 2'b00;
    pair_run(7'h01, 7'h01, b(E_INSTR), 2, 0, 0);
    pair_run(7'h12, 7'h12, b(E_FST) | b(E_RPL), 2, 2, 0);
    {mode_user, mode_exl} = 2'b01;
    cnt_exl = 2'b01;
    pair_run(7'h01, 7'h01, b(E_INSTR), 2, 2, 0);
    {mode_user, mode_exl} = 2'b10;
    cnt_exl = 2'b11;
    mt_mode[0] = pec_pkg::MT_TC;
    mt_mode[1] = pec_pkg::MT_TC;
    cnt_user = 2'b11;
    pair_run(7'h01, 7'h01, b(E_INSTR), 2, 0, 0);
    pair_run(7'h18, 7'h17, b(E_FIX) | b(E_ONE), 2, 2, 0);
    sole_tc = 8'h05;
    pair_run(7'h18, 7'h17, b(E_FIX) | b(E_ONE), 2, 2, 2);
    mt_mode[0] = pec_pkg::MT_VP;
    mt_mode[1] = pec_pkg::MT_RSV;
    pair_run(7'h01, 7'h01, b(E_INSTR), 2, 2, 0);
    mt_mode[0] = pec_pkg::MT_ALL;
    mt_mode[1] = pec_pkg::MT_ALL;
    $display("test qualification done");
  endtask : t_mode

  task automatic t_sys();
    cnt_user = 2'b00;
    for (int k = 0; k < 4; k++) begin
      // Only defined codes are selected
      clear(7'h40 + 7'(k), 7'h40 + 7'(k));
      system_event_in = 8'h03 << (2 * k);
      step(1);
      system_event_in = 8'h01 << (2 * k);
      step(2);
      system_event_in = 8'h00;
      step(5);
      check($sformatf("pin %0d", 2 * k), 32'h0000_0003, count_q[0]);
      check($sformatf("pin %0d", 2 * k + 1), 32'h0000_0001, count_q[1]);
    end
    cnt_user = 2'b11;
    $display("test system pins done");
  endtask : t_sys

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    clk_run = 1'b1;
    rst_n = 1'b0;
    event_sel = '0;
    {cnt_user, cnt_super, cnt_kernel, cnt_exl} = 8'hFF;
    overflow_irq_enable = 2'b00;
    cnt_wr = 2'b00;
    cnt_wdata = 32'h0000_0000;
    mt_mode[0] = pec_pkg::MT_ALL;
    mt_mode[1] = pec_pkg::MT_ALL;
    sel_tc = 16'h0505;
    sel_vp = 8'h11;
    {mode_user, mode_super, mode_kernel, mode_exl} = 4'h8;
    {ev_tc, fixup_tc, sole_tc} = 24'h06_05_06;
    {ev_vp, fixup_vp, sole_vp} = 12'h111;
    system_event_in = 8'h00;
    ev_req = 33'h0_0000_0000;
    step(6);
    rst_n = 1'b1;
    check("reset count0", 32'h0000_0000, count_q[0]);
    check("reset irq", 32'h0000_0000, pec_pkg::count_t'(irq_q));
    t_cycles();
    t_write_irq();
    t_events();
    t_mode();
    t_sys();
    wrap_up();
  end
endmodule : tb
